/* bench/codec_link_props.sv */
/* link timing checks for the slot link and the receiver's output pulses.
   assumes it is instantiated beside the link, all on mclk. */
`timescale 1ns/1ns
module codec_link_props (
  input wire logic       mclk,
  input wire logic       srst,
  input wire logic       sfs,
  input wire logic       sbit,
  input wire logic       ctrl_wvalid,
  input wire logic [3:0] play_valid,
  input wire logic       in_frame
);
  logic [11:0] cyc;       // mclk since the last frame sync
  logic        seen;      // a sync has been seen since reset
  logic [11:0] next_cyc;  // next value of cyc
  logic        next_seen; // next value of seen
  logic [3:0]  slot_ok;   // channel pulse allowed now, either slot set

  // count from each sync; a missing sync only lets the count wrap
  always_comb begin
    next_cyc = sfs ? 12'h001 : cyc + 12'h001;
    next_seen = seen | sfs;
    for (int k = 0; k < 4; k++) begin
      slot_ok[k] = (int'(cyc) == 32'h0C0 + 32'h40 * k) || (int'(cyc) == 32'h4C0 + 32'h40 * k);
    end
  end

  // register the frame position
  always_ff @(posedge mclk) begin
    if (srst) begin
      cyc <= 12'h000;
      seen <= 1'h0;
    end else begin
      cyc <= next_cyc;
      seen <= next_seen;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // three quiet cycles between bit strobes
  sequence gap_three;
    !sbit ##1 !sbit ##1 !sbit;
  endsequence
  // the four samples follow the control word one slot apart
  sequence sample_train;
    play_valid == 4'h1 ##64 play_valid == 4'h2 ##64 play_valid == 4'h4 ##64 play_valid == 4'h8;
  endsequence

  strobe_spacing_a: assert property (sbit |=> gap_three ##1 sbit)
    else $error("bit strobe spacing wrong");
  sync_on_strobe_a: assert property (sfs |-> sbit)
    else $error("frame sync without bit strobe");
  frame_length_a: assert property (sfs && seen |-> cyc == 12'h800)
    else $error("frame length wrong");
  ctrl_slot_time_a: assert property (ctrl_wvalid |-> cyc == 12'h080 || cyc == 12'h480)
    else $error("control word at wrong time");
  sample_slot_time_a: assert property (|play_valid |-> (play_valid & ~slot_ok) == 4'h0)
    else $error("sample at wrong slot");
  slot_order_a: assert property (ctrl_wvalid |-> ##64 sample_train)
    else $error("sample order wrong");
  one_output_a: assert property ((ctrl_wvalid || |play_valid) |->
    in_frame && $onehot0({ctrl_wvalid, play_valid}))
    else $error("output outside frame or overlapping");
  frame_hunt_a: assert property (sfs |-> ##[1:4] in_frame)
    else $error("sync not taken");
endmodule

/* bench/tb_top.sv */
/* bench: master and receiver back to back; each row is one frame.
   assumes the design files are compiled first. */
`timescale 1ns/1ns
module tb_top;
  import codec_slots_pkg::*;
  typedef struct packed {
    sample_fmt_t      f1;  // first converter format
    sample_fmt_t      f2;  // second converter format
    logic             alt; // use slots 17..21
    word_t            cw;  // control word
    logic [3:0][15:0] pw;  // samples, ch3 first
  } row_t;
  // every format on both converters, boundary codes, both slot sets
  localparam row_t ROWS[4] = '{
    '{FMT_LIN16, FMT_LIN8, 1'h0, 16'hA5C3, {16'h0034, 16'hFF12, 16'h7FFF, 16'h8000}},
    '{FMT_ULAW, FMT_ALAW, 1'h1, 16'h5A3C, {16'h55FE, 16'h8001, 16'hFF55, 16'h00AA}},
    '{FMT_LIN8, FMT_ULAW, 1'h0, 16'h0001, {16'h80C3, 16'h7F00, 16'h7F00, 16'h80FF}},
    '{FMT_ALAW, FMT_LIN16, 1'h1, 16'h8000, {16'hFFFF, 16'h0001, 16'h2A77, 16'hD500}}};
  logic             mclk;        // 250 MHz
  logic             srst;        // sync reset
  word_t            ctrl_word;   // control data to send
  sample_fmt_t      fmt_first;   // shared by both ends
  sample_fmt_t      fmt_second;  // shared by both ends
  logic [3:0][15:0] play_word;   // samples to send
  logic             alt_set;     // slot set select
  logic             frame_tick;  // inputs latched
  word_t            ctrl_wdata;  // received control data
  logic             ctrl_wvalid; // control pulse
  logic [3:0][15:0] play_data;   // expanded samples
  logic [3:0]       play_valid;  // sample pulses
  logic             in_frame;    // receiver locked
  logic [8:0]       wire_pos;    // next bit index on the wire
  word_t            wire_sh;     // wire bits, shifted in as sent
  word_t            wire_ctrl;   // control slot seen on the wire
  int               n_fail;
  int               check_count;

  codec_slot_link link();
  dsp_slot_master dsp_slot_master_i (.mclk(mclk), .srst(srst), .link(link),
    .ctrl_word(ctrl_word), .fmt_first(fmt_first), .fmt_second(fmt_second),
    .play_word(play_word), .alt_set(alt_set), .frame_tick(frame_tick));
  codec_slot_receiver codec_slot_receiver_i (.mclk(mclk), .srst(srst), .link(link),
    .fmt_first(fmt_first), .fmt_second(fmt_second), .ctrl_wdata(ctrl_wdata),
    .ctrl_wvalid(ctrl_wvalid), .play_data(play_data), .play_valid(play_valid),
    .in_frame(in_frame));
  codec_link_props codec_link_props_i (.mclk(mclk), .srst(srst), .sfs(link.sfs),
    .sbit(link.sbit), .ctrl_wvalid(ctrl_wvalid), .play_valid(play_valid),
    .in_frame(in_frame));

  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end

  // watch the wire itself: shifting left keeps the first bit on top
  always @(posedge mclk) begin
    if (link.sbit) begin
      wire_sh <= {wire_sh[14:0], link.sdat};
      wire_pos <= link.sfs ? 9'h001 : wire_pos + 9'h001;
      if (!link.sfs && (wire_pos == 9'h01F || wire_pos == 9'h11F)) begin
        wire_ctrl <= {wire_sh[14:0], link.sdat};
      end
    end
  end

  // expected 16-bit signed linear value of one received word
  function automatic word_t expand(input sample_fmt_t f, input word_t w);
    logic [7:0]  b;
    logic [15:0] t;
    b = w[15:8];
    case (f)
      FMT_LIN16: return w;
      FMT_LIN8: return {b ^ 8'h80, 8'h00};
      FMT_ULAW: begin
        b = ~b;
        t = ({12'h000, b[3:0]} << 3) + 16'h0084;
        t = t << b[6:4];
        return b[7] ? 16'h0084 - t : t - 16'h0084;
      end
      default: begin
        b = b ^ 8'h55;
        t = {8'h00, b[3:0], 4'h0} + ((b[6:4] == 3'h0) ? 16'h0008 : 16'h0108);
        if (b[6:4] > 3'h1) t = t << (b[6:4] - 3'h1);
        return b[7] ? t : 16'h0000 - t;
      end
    endcase
  endfunction

  task automatic check(input word_t got, input word_t exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // wait for one pulse: 0 control, 1..4 channel, 5 frame_tick; bounded
  task automatic wait_out(input int k);
    int n;
    n = 0;
    @(negedge mclk);
    while ((k == 0 ? ctrl_wvalid : k == 5 ? frame_tick : play_valid[k-1]) !== 1'h1
           && n < 2200) begin
      @(negedge mclk);
      n++;
    end
    if (n >= 2200) check(16'h0000, 16'h0001);
  endtask

  // one frame: inputs held until latched, then the control word and all four samples compared
  task automatic run_row(input row_t r);
    @(posedge mclk);
    fmt_first <= r.f1;
    fmt_second <= r.f2;
    alt_set <= r.alt;
    ctrl_word <= r.cw;
    play_word <= r.pw;
    wait_out(5);
    // the alternate set starts half a frame later; skip the idle set
    if (r.alt) repeat (1024) @(negedge mclk);
    wait_out(0);
    check(ctrl_wdata, r.cw);
    check(wire_ctrl, r.cw);
    for (int k = 0; k < 4; k++) begin
      wait_out(k + 1);
      check(play_data[k], expand(k < 2 ? r.f1 : r.f2, r.pw[k]));
    end
  endtask

  task automatic stop_test;
    if (n_fail == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    #200000;
    n_fail++;
    stop_test();
  end

  initial begin
    n_fail = 0;
    check_count = 0;
    srst = 1'h1;
    ctrl_word = 16'h0000;
    fmt_first = FMT_LIN16;
    fmt_second = FMT_LIN16;
    play_word = '0;
    alt_set = 1'h0;
    repeat (8) @(posedge mclk);
    srst <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      run_row(ROWS[i]);
    end
    // reset in mid-frame clears the receiver, then it locks again
    @(posedge mclk);
    srst <= 1'h1;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    check({7'h00, in_frame, play_valid, ctrl_wvalid, frame_tick, link.sfs, link.sbit},
          16'h0000);
    @(posedge mclk);
    srst <= 1'h0;
    run_row(ROWS[1]);
    stop_test();
  end
endmodule

/* hdl/codec_slot_link.sv */
/*
  serial link between the dsp port master and the codec input slots.
  assumes both ends sit on mclk; all three wires are driven by the master.
*/
`timescale 1ns/1ns
interface codec_slot_link;
  logic sfs;   // frame sync, high with the first bit of slot 0
  logic sbit;  // bit strobe, one mclk high per serial bit
  logic sdat;  // serial data, msb first
  modport master (output sfs, output sbit, output sdat);
  modport codec  (input sfs, input sbit, input sdat);
endinterface

/* hdl/codec_slot_receiver.sv */
/*
  codec side of the link: assembles 16-bit slot words, hands on control
  write data and four playback samples expanded to 16-bit signed linear.
  assumes the link wires come from another chip, so each passes two flops.
*/
`timescale 1ns/1ns
module codec_slot_receiver (
  input  wire logic                         mclk,
  input  wire logic                         srst,
  codec_slot_link.codec                     link,
  input  wire codec_slots_pkg::sample_fmt_t fmt_first,
  input  wire codec_slots_pkg::sample_fmt_t fmt_second,
  output codec_slots_pkg::word_t            ctrl_wdata,
  output logic                              ctrl_wvalid,
  output logic [3:0][15:0]                  play_data,
  output logic [3:0]                        play_valid,
  output logic                              in_frame
);
  import codec_slots_pkg::*;

  // receiver framing state; one bit, so gray by construction
  typedef enum logic {
    ST_HUNT = 1'b0,  // waiting for a frame sync
    ST_RUN  = 1'b1   // counting slots
  } rx_state_t;

  // input synchronisers, same depth so the three wires stay aligned
  logic [2:0] sync_a;  // first stage, read only by sync_b
  logic [2:0] sync_b;  // second stage, safe to use
  logic       fs_s;
  logic       bit_s;
  logic       dat_s;

  // framing state
  rx_state_t  state, next_state;
  logic [3:0] bit_cnt, next_bit_cnt;  // bit within current slot
  logic [4:0] slot, next_slot;        // slot within frame
  word_t      shift, next_shift;      // bits gathered so far
  logic       done, next_done;        // a whole word just landed
  word_t      word, next_word;        // the landed word
  logic [4:0] word_slot, next_word_slot;

  // output stage
  word_t            next_ctrl_wdata;
  logic             next_ctrl_wvalid;
  logic [3:0][15:0] next_play_data;
  logic [3:0]       next_play_valid;
  logic [3:0]       base;             // slot number folded onto 1..5
  logic             in_set;           // word_slot lies in either set

  always_ff @(posedge mclk) begin
    if (srst) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else begin
      sync_a <= {link.sfs, link.sbit, link.sdat};
      sync_b <= sync_a;
    end
  end

  assign fs_s  = sync_b[2];
  assign bit_s = sync_b[1];
  assign dat_s = sync_b[0];

  // mu-law byte to 16-bit signed; bias added then removed after the shift
  function automatic word_t ulaw_expand(input logic [7:0] code);
    logic [7:0]  u;
    logic [15:0] mag;
    u   = ~code;
    mag = 16'(({8'h00, 1'b0, u[3:0], 3'h0} + {8'h00, ULAW_BIAS}) << u[6:4]);
    mag = mag - {8'h00, ULAW_BIAS};
    return u[7] ? 16'(-mag) : mag;
  endfunction

  // a-law byte to 16-bit signed; segment 0 has no implied leading one
  function automatic word_t alaw_expand(input logic [7:0] code);
    logic [7:0]  a;
    logic [15:0] mag;
    a = code ^ ALAW_INV;
    if (a[6:4] == 3'h0) begin
      mag = {8'h00, a[3:0], 4'h8};
    end else begin
      mag = 16'(({7'h00, 1'b0, a[3:0], 4'h0} + {7'h00, ALAW_BIAS}) << (a[6:4] - 3'h1));
    end
    return a[7] ? mag : 16'(-mag);
  endfunction

  // one sample word to linear, per the converter's selected format
  function automatic word_t to_linear(input word_t w, input sample_fmt_t f);
    word_t r;
    r = w;
    case (f)
      FMT_LIN16: r = w;
      FMT_LIN8:  r = {w[15:8] ^ SIGN_FLIP, 8'h00};
      FMT_ULAW:  r = ulaw_expand(w[15:8]);
      FMT_ALAW:  r = alaw_expand(w[15:8]);
      default:   r = w;
    endcase
    return r;
  endfunction

  // framing: a sync bit restarts slot 0, a strobe without sync shifts on only in ST_RUN
  always_comb begin
    next_state     = state;
    next_bit_cnt   = bit_cnt;
    next_slot      = slot;
    next_shift     = shift;
    next_done      = 1'b0;
    next_word      = word;
    next_word_slot = word_slot;
    if (bit_s) begin
      if (fs_s) begin
        // resync every frame so a slipped bit costs at most one frame
        next_state   = ST_RUN;
        next_bit_cnt = 4'h1;
        next_slot    = SLOT_STATUS;
        next_shift   = {15'h0000, dat_s};
      end else begin
        case (state)
          ST_HUNT: begin
            next_state = ST_HUNT;  // nothing trusted before the next sync
          end
          ST_RUN: begin
            next_shift   = {shift[14:0], dat_s};     // msb first
            next_bit_cnt = bit_cnt + 4'h1;
            if (bit_cnt == LAST_BIT) begin
              next_done      = 1'b1;
              next_word      = {shift[14:0], dat_s};
              next_word_slot = slot;
              next_slot      = slot + 5'h1;
              if (slot == LAST_SLOT) begin
                next_state = ST_HUNT;  // last bit of slot 31, every frame: hunt until the next sync
              end
            end
          end
          default: begin
            next_state = ST_HUNT;
          end
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state     <= ST_HUNT;
      bit_cnt   <= 4'h0;
      slot      <= 5'h0;
      shift     <= '0;
      done      <= 1'b0;
      word      <= '0;
      word_slot <= 5'h0;
    end else begin
      state     <= next_state;
      bit_cnt   <= next_bit_cnt;
      slot      <= next_slot;
      shift     <= next_shift;
      done      <= next_done;
      word      <= next_word;
      word_slot <= next_word_slot;
    end
  end

  // both slot sets fold onto 1..5; the alternate set sits 16 slots later
  assign base   = word_slot[3:0];
  assign in_set = (word_slot[3] == 1'b0) && (base >= SLOT_CTRL) && (base <= SLOT_CHN);

  // control slot steering; valid is a one-cycle pulse per landed word
  always_comb begin
    next_ctrl_wdata  = ctrl_wdata;
    next_ctrl_wvalid = 1'b0;
    if (done && in_set && base == SLOT_CTRL) begin
      next_ctrl_wdata  = word;
      next_ctrl_wvalid = 1'b1;
    end
  end

  // one sample channel per generate entry; channels 0,1 use the first format
  for (genvar ch = 0; ch < CH_COUNT; ch++) begin : g_ch
    always_comb begin
      next_play_data[ch]  = play_data[ch];
      next_play_valid[ch] = 1'b0;
      if (done && in_set && base == SLOT_CH0 + 4'(ch)) begin
        next_play_data[ch]  = to_linear(word, (ch < 2) ? fmt_first : fmt_second);
        next_play_valid[ch] = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_wdata  <= '0;
      ctrl_wvalid <= 1'b0;
      play_data   <= '0;
      play_valid  <= 4'h0;
    end else begin
      ctrl_wdata  <= next_ctrl_wdata;
      ctrl_wvalid <= next_ctrl_wvalid;
      play_data   <= next_play_data;
      play_valid  <= next_play_valid;
    end
  end

  assign in_frame = (state == ST_RUN);
endmodule

/* hdl/codec_slots_pkg.sv */
/*
  shared constants and types for the codec serial input slots link.
  assumes one 250 MHz clock for both ends; the link runs at a divided bit rate.
*/
package codec_slots_pkg;
  localparam int unsigned WORD_BITS   = 16;          // bits per slot word
  localparam int unsigned SLOT_BITS   = 5;           // slot counter width
  localparam int unsigned CH_COUNT    = 4;           // playback channels
  localparam logic [3:0]  LAST_BIT    = 4'hF;        // index of a word's last bit
  localparam logic [4:0]  LAST_SLOT   = 5'h1F;       // 32 slots per frame
  localparam logic [4:0]  SLOT_STATUS = 5'h00;       // frame sync slot
  localparam logic [3:0]  SLOT_CTRL   = 4'h1;        // control data, slot 1 or 17
  localparam logic [3:0]  SLOT_CH0    = 4'h2;        // first sample slot, 2 or 18
  localparam logic [3:0]  SLOT_CHN    = 4'h5;        // last sample slot, 5 or 21
  localparam logic [4:0]  SLOT_ALT    = 5'h10;       // offset of the alternate set
  localparam logic [1:0]  BIT_DIV_END = 2'h3;        // bit strobe every 4 mclk
  localparam logic [7:0]  ULAW_BIAS   = 8'h84;       // mu-law expansion bias
  localparam logic [8:0]  ALAW_BIAS   = 9'h108;      // a-law segment offset
  localparam logic [7:0]  ALAW_INV    = 8'h55;       // a-law even-bit inversion
  localparam logic [7:0]  SIGN_FLIP   = 8'h80;       // unsigned to signed byte

  // sample word format of one playback converter
  typedef enum logic [1:0] {
    FMT_LIN16 = 2'h0,
    FMT_LIN8  = 2'h1,
    FMT_ULAW  = 2'h2,
    FMT_ALAW  = 2'h3
  } sample_fmt_t;

  typedef logic [WORD_BITS-1:0] word_t;
endpackage

/* hdl/dsp_slot_master.sv */
/*
  dsp side of the link: shifts control data and four playback samples into
  slots 1..5 or 17..21 of each 32-slot frame.
  assumes user ports are held stable around frame_tick; all but fmt_first and fmt_second are latched there.
*/
`timescale 1ns/1ns
module dsp_slot_master (
  input  wire logic                         mclk,
  input  wire logic                         srst,
  codec_slot_link.master                    link,
  input  wire codec_slots_pkg::word_t       ctrl_word,
  input  wire codec_slots_pkg::sample_fmt_t fmt_first,
  input  wire codec_slots_pkg::sample_fmt_t fmt_second,
  input  wire logic [3:0][15:0]             play_word,
  input  wire logic                         alt_set,
  output logic                              frame_tick
);
  import codec_slots_pkg::*;

  logic [1:0]       div_cnt, next_div_cnt;     // bit rate divider
  logic [3:0]       bit_cnt, next_bit_cnt;     // bit within slot
  logic [4:0]       slot, next_slot;           // slot within frame
  word_t            shift, next_shift;         // outgoing word
  logic             sfs, next_sfs;
  logic             sbit, next_sbit;
  logic             sdat, next_sdat;
  logic             tick, next_tick;
  word_t            ctrl_hold, next_ctrl_hold; // latched at frame start
  logic [3:0][15:0] play_hold, next_play_hold;
  logic             alt_hold, next_alt_hold;
  logic             strobe;
  logic [4:0]       base;
  word_t            cur;
  sample_fmt_t      f;

  assign strobe = (div_cnt == BIT_DIV_END);
  assign base   = alt_hold ? (slot - SLOT_ALT) : slot;

  // word for the slot about to start; 8-bit formats go out in the upper byte
  always_comb begin
    cur = '0;
    f   = FMT_LIN16;
    if (base == {1'b0, SLOT_CTRL}) begin
      cur = ctrl_hold;
    end else if (base >= {1'b0, SLOT_CH0} && base <= {1'b0, SLOT_CHN}) begin
      cur = play_hold[base[1:0] - 2'h2];
      f   = (base[1:0] == 2'h2 || base[1:0] == 2'h3) ? fmt_first : fmt_second;
      if (f != FMT_LIN16) begin
        cur[7:0] = 8'h00;                           // low byte unused
      end
    end
  end

  // counters, shifter and latching for one frame
  always_comb begin
    next_div_cnt   = strobe ? 2'h0 : div_cnt + 2'h1;
    next_bit_cnt   = bit_cnt;
    next_slot      = slot;
    next_shift     = shift;
    next_sfs       = 1'b0;
    next_sbit      = strobe;
    next_sdat      = sdat;
    next_tick      = 1'b0;
    next_ctrl_hold = ctrl_hold;
    next_play_hold = play_hold;
    next_alt_hold  = alt_hold;
    if (strobe) begin
      next_bit_cnt = bit_cnt + 4'h1;
      if (bit_cnt == LAST_BIT) begin
        next_slot = slot + 5'h1;
      end
      if (bit_cnt == 4'h0) begin
        next_sdat  = cur[15];                       // msb first
        next_shift = {cur[14:0], 1'b0};
        next_sfs   = (slot == SLOT_STATUS);
      end else begin
        next_sdat  = shift[15];
        next_shift = {shift[14:0], 1'b0};
      end
      if (bit_cnt == LAST_BIT && slot == LAST_SLOT) begin
        next_ctrl_hold = ctrl_word;
        next_play_hold = play_word;
        next_alt_hold  = alt_set;
        next_tick      = 1'b1;
      end
    end
  end

  // registers only
  always_ff @(posedge mclk) begin
    if (srst) begin
      div_cnt   <= 2'h0;
      bit_cnt   <= 4'h0;
      slot      <= 5'h0;
      shift     <= '0;
      sfs       <= 1'b0;
      sbit      <= 1'b0;
      sdat      <= 1'b0;
      tick      <= 1'b0;
      ctrl_hold <= '0;
      play_hold <= '0;
      alt_hold  <= 1'b0;
    end else begin
      div_cnt   <= next_div_cnt;
      bit_cnt   <= next_bit_cnt;
      slot      <= next_slot;
      shift     <= next_shift;
      sfs       <= next_sfs;
      sbit      <= next_sbit;
      sdat      <= next_sdat;
      tick      <= next_tick;
      ctrl_hold <= next_ctrl_hold;
      play_hold <= next_play_hold;
      alt_hold  <= next_alt_hold;
    end
  end

  assign link.sfs   = sfs;
  assign link.sbit  = sbit;
  assign link.sdat  = sdat;
  assign frame_tick = tick;
endmodule
